// ==== logic/pin_sync.sv ====
// Purpose: Two-flop synchroniser for a group of pins
// Assumes: Pins are asynchronous to sys_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinOut
);
	logic [W-1:0] meta_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= '0;
			pinOut <= '0;
		end else begin
			meta_q <= pinIn;
			pinOut <= meta_q;
		end
	end
endmodule

// ==== logic/position_teach_capture.sv ====
// Purpose: Teach current position into one of eight stored target slots
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   Pins synchronised before use
// How it works
// (R1) Terminal is teach input when code 45
// (R2) Teaching only in absolute modes 02/03
// (R3) Run start latches speed and acceleration profile
// (R4) Position counter follows encoder, driven or not
// (R5) Store key writes position into selected slot
// (R6) Slot select 00..07 maps to slots 0..7
// (R7) Slot select is volatile, resets to 00
// (R8) Operator presses store key when value shown
// (R9) Three weighted select bits pick slot, default 0
// (R10) Position clear zeroes position and deviation counters
// (R11) One capture per store key press
`timescale 1ns/1ns
module position_teach_capture
	import teach_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      rst_b,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic [31:0]                    hrdata,
	output logic                           hresp,
	input  wire logic [teach_pkg::NUM_TERM-1:0] termPin,
	input  wire logic                      runPin,
	input  wire logic                      storeKeyPin,
	input  wire logic                      encStepPin,
	input  wire logic                      encDirPin,
	output logic                           driveRun,
	output teach_pkg::profile_s            driveProfile,
	output logic [teach_pkg::POS_W-1:0]    targetPosition,
	output logic [teach_pkg::SLOT_W-1:0]   activeSlot,
	output logic                           teachActive
);
	import teach_pkg::*;

	function automatic logic inBlock(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
		inBlock = (a[ADDR_W-1:BLOCK_LSB] == base[ADDR_W-1:BLOCK_LSB]);
	endfunction

	logic [NUM_TERM+3:0] pinSync;
	logic [NUM_TERM-1:0] termLvl;
	logic                runS, storeS, stepS, dirS;

	pin_sync #(.W(NUM_TERM+4)) u_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.pinIn   ({termPin, runPin, storeKeyPin, encStepPin, encDirPin}),
		.pinOut  (pinSync)
	);
	assign {termLvl, runS, storeS, stepS, dirS} = pinSync;

	// Configuration and bus state
	logic [7:0]          mode_q, mode_d;
	logic [SLOT_W-1:0]   sel_q, sel_d;
	logic [CODE_W-1:0]   func_q [NUM_TERM];
	logic [CODE_W-1:0]   func_d [NUM_TERM];
	logic [POS_W-1:0]    slot_q [NUM_SLOT];
	logic [POS_W-1:0]    slot_d [NUM_SLOT];
	logic [POS_W-1:0]    speed_q, speed_d, accel_q, accel_d;
	logic                wrPend_q, wrPend_d;
	logic [ADDR_W-1:0]   wrAddr_q, wrAddr_d;
	logic [31:0]         rdata_q, rdata_d, rdMux;
	// Motion state
	logic [POS_W-1:0]    pos_q, pos_d, dev_q, dev_d, target_q, target_d;
	logic                storePrev_q, storePrev_d, stepPrev_q, stepPrev_d;
	logic                runPrev_q, runPrev_d;
	drive_e              state_q, state_d;
	profile_s            prof_q, prof_d;

	term_s               term;
	logic                captureFire, stepEdge, runEdge, modeAbs;
	logic [ADDR_W-1:0]   aAddr;

	// Terminal function decode
	always_comb begin
		term = '0;
		for (int i = 0; i < NUM_TERM; i++) begin
			if (func_q[i] == FUNC_TEACH && termLvl[i]) term.teach = 1'b1; // R1
			if (func_q[i] == FUNC_POS_CLEAR && termLvl[i]) term.posClear = 1'b1;
			if (func_q[i] == FUNC_CP1 || func_q[i] == FUNC_CP2 || func_q[i] == FUNC_CP3)
				term.cpAssigned = 1'b1;
			if (func_q[i] == FUNC_CP1 && termLvl[i]) term.cpSel[0] = 1'b1; // R9
			if (func_q[i] == FUNC_CP2 && termLvl[i]) term.cpSel[1] = 1'b1; // R9
			if (func_q[i] == FUNC_CP3 && termLvl[i]) term.cpSel[2] = 1'b1; // R9
		end
	end

	assign modeAbs     = (mode_q == MODE_ABS) || (mode_q == MODE_ABS_HR); // R2
	assign teachActive = modeAbs && term.teach; // R1 R2
	assign activeSlot  = term.cpAssigned ? term.cpSel : SEL_RST; // R9
	assign captureFire = teachActive && storeS && !storePrev_q; // R5 R11
	assign stepEdge    = stepS && !stepPrev_q;
	assign runEdge     = runS && !runPrev_q;
	assign aAddr       = haddr[ADDR_W-1:0];

	// Read mux
	always_comb begin
		rdMux = 32'h0;
		if (aAddr == ADDR_MODE) rdMux = {24'h0, mode_q};
		else if (aAddr == ADDR_TEACH_SEL) rdMux = {29'h0, sel_q};
		else if (aAddr == ADDR_STATUS) begin
			rdMux[STAT_TEACH] = teachActive;
			rdMux[STAT_RUN] = (state_q == DRV_RUN);
			rdMux[STAT_CP_ASSIGN] = term.cpAssigned;
			rdMux[STAT_SLOT_LSB +: SLOT_W] = activeSlot;
		end
		else if (aAddr == ADDR_CUR_POS) rdMux = pos_q;
		else if (aAddr == ADDR_SPEED) rdMux = speed_q;
		else if (aAddr == ADDR_ACCEL) rdMux = accel_q;
		else if (aAddr == ADDR_DEVIATION) rdMux = dev_q;
		else if (inBlock(aAddr, ADDR_FUNC_BASE)) rdMux = {24'h0, func_q[aAddr[4:2]]};
		else if (inBlock(aAddr, ADDR_SLOT_BASE)) rdMux = slot_q[aAddr[4:2]];
	end

	always_comb begin
		mode_d   = mode_q;
		sel_d    = sel_q;
		func_d   = func_q;
		slot_d   = slot_q;
		speed_d  = speed_q;
		accel_d  = accel_q;
		wrPend_d = hsel && hready && htrans[1] && hwrite;
		wrAddr_d = aAddr;
		rdata_d  = rdata_q;
		if (hsel && hready && htrans[1] && !hwrite) rdata_d = rdMux;
		if (wrPend_q) begin
			if (wrAddr_q == ADDR_MODE) mode_d = hwdata[7:0];
			else if (wrAddr_q == ADDR_TEACH_SEL) sel_d = hwdata[SLOT_W-1:0];
			else if (wrAddr_q == ADDR_SPEED) speed_d = hwdata;
			else if (wrAddr_q == ADDR_ACCEL) accel_d = hwdata;
			else if (inBlock(wrAddr_q, ADDR_FUNC_BASE)) func_d[wrAddr_q[4:2]] = hwdata[7:0];
			else if (inBlock(wrAddr_q, ADDR_SLOT_BASE)) slot_d[wrAddr_q[4:2]] = hwdata;
		end
		// Capture wins over a bus write to the same slot
		if (captureFire) slot_d[sel_q] = pos_q; // R5 R6
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q   <= MODE_RST;
			sel_q    <= SEL_RST; // R7
			for (int i = 0; i < NUM_TERM; i++) func_q[i] <= FUNC_NONE;
			for (int i = 0; i < NUM_SLOT; i++) slot_q[i] <= '0;
			speed_q  <= '0;
			accel_q  <= '0;
			wrPend_q <= 1'b0;
			wrAddr_q <= '0;
			rdata_q  <= 32'h0;
		end else begin
			mode_q   <= mode_d;
			sel_q    <= sel_d;
			func_q   <= func_d;
			slot_q   <= slot_d;
			speed_q  <= speed_d;
			accel_q  <= accel_d;
			wrPend_q <= wrPend_d;
			wrAddr_q <= wrAddr_d;
			rdata_q  <= rdata_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY[0];
	assign hrdata    = rdata_q;

	// Position, deviation and drive
	always_comb begin
		pos_d       = pos_q;
		storePrev_d = storeS; // R11
		stepPrev_d  = stepS;
		runPrev_d   = runS;
		state_d     = state_q;
		prof_d      = prof_q;
		target_d    = slot_q[activeSlot]; // R9
		if (stepEdge) pos_d = dirS ? pos_q + 32'h1 : pos_q - 32'h1; // R4
		if (term.posClear) pos_d = '0; // R10
		case (state_q)
			DRV_IDLE: begin
				if (runEdge) begin
					state_d = DRV_RUN;
					prof_d  = '{speed: speed_q, accel: accel_q}; // R3
				end
			end
			DRV_RUN: begin
				if (!runS) state_d = DRV_IDLE;
			end
			default: state_d = DRV_IDLE;
		endcase
		dev_d = (state_q == DRV_RUN) ? target_q - pos_q : '0;
		if (term.posClear) dev_d = '0; // R10
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pos_q       <= '0;
			dev_q       <= '0;
			target_q    <= '0;
			storePrev_q <= 1'b0;
			stepPrev_q  <= 1'b0;
			runPrev_q   <= 1'b0;
			state_q     <= DRV_IDLE;
			prof_q      <= '0;
		end else begin
			pos_q       <= pos_d;
			dev_q       <= dev_d;
			target_q    <= target_d;
			storePrev_q <= storePrev_d;
			stepPrev_q  <= stepPrev_d;
			runPrev_q   <= runPrev_d;
			state_q     <= state_d;
			prof_q      <= prof_d;
		end
	end

	assign driveRun       = (state_q == DRV_RUN);
	assign driveProfile   = prof_q;
	assign targetPosition = target_q;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	logic teachRef;
	always_comb begin
		teachRef = 1'b0;
		for (int i = 0; i < NUM_TERM; i++)
			if (func_q[i] == 8'h2d && termLvl[i]) teachRef = 1'b1;
	end

	a_teach_code: assert property (teachActive |-> teachRef) // R1
		else $error("teach active without a teach terminal");
	a_teach_mode: assert property (!(mode_q == 8'h02 || mode_q == 8'h03) |-> !teachActive) // R2
		else $error("teach active outside absolute modes");
	a_profile_latch: assert property ($rose(driveRun) |-> driveProfile == {$past(speed_q), $past(accel_q)}) // R3
		else $error("run profile not taken at run start");
	a_profile_hold: assert property (driveRun && $past(driveRun) |-> $stable(driveProfile)) // R3
		else $error("run profile changed during run");
	a_pos_count: assert property (stepEdge && !term.posClear |=> pos_q == $past(pos_q) + ($past(dirS) ? 32'h1 : 32'hffffffff)) // R4
		else $error("position counter missed a step");
	a_capture_write: assert property (captureFire |=> slot_q[$past(sel_q)] == $past(pos_q)) // R5 R6
		else $error("capture did not store position");
	a_sel_reset: assert property (!$past(rst_b) |-> sel_q == 3'h0) // R7
		else $error("slot select not zero after reset");
	a_slot_default: assert property (!term.cpAssigned |-> activeSlot == 3'h0) // R9
		else $error("active slot not zero with no select bits");
	a_pos_clear: assert property (term.posClear |=> pos_q == 32'h0 && dev_q == 32'h0) // R10
		else $error("clear did not zero counters");
	a_single_capture: assert property (captureFire |=> !captureFire) // R11
		else $error("held store key captured twice");

	c_capture:     cover property (captureFire);
	c_teach_run:   cover property (teachActive && runEdge);
	c_clear:       cover property (term.posClear && stepEdge);
	c_select_high: cover property (term.cpAssigned && activeSlot == 3'h7);
endmodule

// ==== logic/teach_pkg.sv ====
// Purpose: Shared constants and types for the position teach block
// Assumes: 32-bit AHB-Lite register map, 12 address bits decoded
// Notes:   Function codes are decimal values written in hex
package teach_pkg;
	localparam int          POS_W          = 32;
	localparam int          NUM_TERM       = 8;
	localparam int          NUM_SLOT       = 8;
	localparam int          SLOT_W         = 3;
	localparam int          CODE_W         = 8;
	localparam int          ADDR_W         = 12;
	localparam int          BLOCK_LSB      = 5;
	// Terminal function codes
	localparam logic [7:0]  FUNC_TEACH     = 8'h2d;
	localparam logic [7:0]  FUNC_POS_CLEAR = 8'h2f;
	localparam logic [7:0]  FUNC_CP1       = 8'h42;
	localparam logic [7:0]  FUNC_CP2       = 8'h43;
	localparam logic [7:0]  FUNC_CP3       = 8'h44;
	localparam logic [7:0]  FUNC_NONE      = 8'hff;
	// Control pulse modes
	localparam logic [7:0]  MODE_ABS       = 8'h02;
	localparam logic [7:0]  MODE_ABS_HR    = 8'h03;
	// Register byte offsets
	localparam logic [11:0] ADDR_MODE      = 12'h000;
	localparam logic [11:0] ADDR_TEACH_SEL = 12'h004;
	localparam logic [11:0] ADDR_STATUS    = 12'h008;
	localparam logic [11:0] ADDR_CUR_POS   = 12'h00c;
	localparam logic [11:0] ADDR_SPEED     = 12'h010;
	localparam logic [11:0] ADDR_ACCEL     = 12'h014;
	localparam logic [11:0] ADDR_DEVIATION = 12'h018;
	localparam logic [11:0] ADDR_FUNC_BASE = 12'h020;
	localparam logic [11:0] ADDR_SLOT_BASE = 12'h040;
	// Reset values
	localparam logic [7:0]  MODE_RST       = 8'h00;
	localparam logic [2:0]  SEL_RST        = 3'h0;
	// Status fields
	localparam int          STAT_TEACH     = 0;
	localparam int          STAT_RUN       = 1;
	localparam int          STAT_CP_ASSIGN = 2;
	localparam int          STAT_SLOT_LSB  = 4;
	// AHB constants
	localparam logic [1:0]  HRESP_OKAY     = 2'h0;

	typedef struct packed {
		logic             teach;
		logic             posClear;
		logic             cpAssigned;
		logic [SLOT_W-1:0] cpSel;
	} term_s;

	typedef struct packed {
		logic [POS_W-1:0] speed;
		logic [POS_W-1:0] accel;
	} profile_s;

	typedef enum logic {
		DRV_IDLE = 1'b0,
		DRV_RUN  = 1'b1
	} drive_e;
endpackage

// ==== testbench/position_teach_capture_bench.sv ====
// Purpose: Self-checking bench for the position teach block
// Assumes: Zero wait AHB slave, partner model on the pins
// Notes:   Expected position tracked from steps sent
`timescale 1ns/1ns
module position_teach_capture_bench;
	import teach_pkg::*;
	logic                 sys_clk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 hsel = 1'b0;
	logic                 hwrite = 1'b0;
	logic [1:0]           htrans = 2'h0;
	logic [31:0]          haddr = 32'h0;
	logic [31:0]          hwdata = 32'h0;
	logic [31:0]          hrdata;
	logic                 hready;
	logic                 hresp;
	logic [NUM_TERM-1:0]  termPin;
	logic                 runPin;
	logic                 storeKeyPin;
	logic                 encStepPin;
	logic                 encDirPin;
	logic                 driveRun;
	profile_s             driveProfile;
	logic [POS_W-1:0]     targetPosition;
	logic [SLOT_W-1:0]    activeSlot;
	logic                 teachActive;
	int                   n_mismatch = 0;
	int                   checks = 0;
	int                   cycles = 0;
	logic [31:0]          expPos = 32'h0;
	logic [2:0]           hsize = 3'h0;
	logic [19:0]          hiAddr = 20'h0;
	always #5 sys_clk = ~sys_clk;
	position_teach_capture i_position_teach_capture (.sys_clk(sys_clk), .rst_b(rst_b),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
		.hresp(hresp), .termPin(termPin), .runPin(runPin), .storeKeyPin(storeKeyPin),
		.encStepPin(encStepPin), .encDirPin(encDirPin), .driveRun(driveRun),
		.driveProfile(driveProfile), .targetPosition(targetPosition),
		.activeSlot(activeSlot), .teachActive(teachActive));
	teach_partner i_teach_partner (.sys_clk(sys_clk), .termPin(termPin), .runPin(runPin),
		.storeKeyPin(storeKeyPin), .encStepPin(encStepPin), .encDirPin(encDirPin));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {hiAddr, a};
		hsize <= 3'h2;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
	endtask
	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		hsel <= 1'b1;
		haddr <= {hiAddr, a};
		hsize <= 3'h2;
		htrans <= 2'h2;
		hwrite <= 1'b0;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		do @(posedge sys_clk); while (hready !== 1'b1);
		chk(what, exp, hrdata);
		chk("response", 32'h0, {31'h0, hresp});
	endtask
	task automatic t_reset();
		rdchk("teach select", ADDR_TEACH_SEL, 32'h0);
		rdchk("mode", ADDR_MODE, 32'h0);
		rdchk("unmapped", 12'h0fc, 32'h0);
		hiAddr = 20'habcde;
		wr(ADDR_MODE, 32'h07);
		rdchk("mode upper address", ADDR_MODE, 32'h7);
		hiAddr = 20'h0;
		chk("active slot", 32'h0, {29'h0, activeSlot});
		$display("test reset done");
	endtask
	task automatic t_enable();
		logic [7:0] m;
		wr(ADDR_FUNC_BASE, 32'h2c);
		wr(ADDR_MODE, 32'h02);
		i_teach_partner.setTerms(8'h01);
		chk("teach wrong code", 32'h0, {31'h0, teachActive});
		wr(ADDR_FUNC_BASE, 32'h2d);
		for (int i = 0; i < 5; i++) begin
			m = 8'(i);
			wr(ADDR_MODE, {24'h0, m});
			@(posedge sys_clk);
			chk("teach active", {31'h0, m == 8'h02 || m == 8'h03}, {31'h0, teachActive});
		end
		wr(ADDR_MODE, 32'h02);
		$display("test enable done");
	endtask
	task automatic t_capture();
		for (int i = 0; i < 5; i++) i_teach_partner.step(1'b1);
		for (int i = 0; i < 2; i++) i_teach_partner.step(1'b0);
		expPos = 32'h3;
		rdchk("position", ADDR_CUR_POS, expPos);
		for (int s = 0; s < 8; s++) begin
			wr(ADDR_TEACH_SEL, 32'(s));
			i_teach_partner.step(1'b1);
			expPos++;
			i_teach_partner.press(5);
			rdchk("slot", ADDR_SLOT_BASE + 12'(4 * s), expPos);
		end
		wr(ADDR_TEACH_SEL, 32'h0);
		fork
			i_teach_partner.press(30);
			begin
				repeat (8) @(posedge sys_clk);
				i_teach_partner.step(1'b1);
			end
		join
		rdchk("held key slot", ADDR_SLOT_BASE, expPos);
		expPos++;
		wr(ADDR_MODE, 32'h01);
		i_teach_partner.press(5);
		rdchk("refused slot", ADDR_SLOT_BASE, expPos - 32'h1);
		$display("test capture done");
	endtask
	task automatic t_clear();
		wr(ADDR_FUNC_BASE + 12'h004, 32'h2f);
		i_teach_partner.setTerms(8'h03);
		rdchk("cleared position", ADDR_CUR_POS, 32'h0);
		rdchk("cleared deviation", ADDR_DEVIATION, 32'h0);
		i_teach_partner.setTerms(8'h01);
		$display("test clear done");
	endtask
	task automatic t_select();
		for (int k = 0; k < 8; k++) wr(ADDR_SLOT_BASE + 12'(4 * k), 32'h1000 + 32'(k));
		for (int k = 0; k < 3; k++) wr(ADDR_FUNC_BASE + 12'(20 + 4 * k), 32'h42 + 32'(k));
		for (int k = 0; k < 8; k++) begin
			i_teach_partner.setTerms(8'h01 | 8'(k << 5));
			chk("active slot", 32'(k), {29'h0, activeSlot});
			chk("target", 32'h1000 + 32'(k), targetPosition);
		end
		rdchk("status", ADDR_STATUS, 32'h74);
		$display("test select done");
	endtask
	task automatic t_run();
		wr(ADDR_SPEED, 32'h100);
		wr(ADDR_ACCEL, 32'h20);
		i_teach_partner.setRun(1'b1);
		chk("run", 32'h1, {31'h0, driveRun});
		wr(ADDR_SPEED, 32'h999);
		chk("speed", 32'h100, driveProfile.speed);
		chk("accel", 32'h20, driveProfile.accel);
		rdchk("run deviation", ADDR_DEVIATION, 32'h1007);
		i_teach_partner.setTerms(8'he3);
		rdchk("run deviation clear", ADDR_DEVIATION, 32'h0);
		rdchk("run position clear", ADDR_CUR_POS, 32'h0);
		i_teach_partner.setTerms(8'he1);
		i_teach_partner.setRun(1'b0);
		chk("stopped", 32'h0, {31'h0, driveRun});
		$display("test run done");
	endtask
	task automatic t_rereset();
		wr(ADDR_TEACH_SEL, 32'h5);
		rdchk("select before reset", ADDR_TEACH_SEL, 32'h5);
		rst_b <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rdchk("select after reset", ADDR_TEACH_SEL, 32'h0);
		$display("test rereset done");
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_enable();
		t_capture();
		t_clear();
		t_select();
		t_run();
		t_rereset();
		report_and_stop();
	end
endmodule

// ==== testbench/teach_partner.sv ====
// Purpose: Keypad, terminal and encoder model for the teach block
// Assumes: Called right after a rising edge of sys_clk
// Notes:   Each action ends with four settle cycles for the pin sync
`timescale 1ns/1ns
module teach_partner
	import teach_pkg::*;
(
	input  wire logic                      sys_clk,
	output logic [teach_pkg::NUM_TERM-1:0] termPin,
	output logic                           runPin,
	output logic                           storeKeyPin,
	output logic                           encStepPin,
	output logic                           encDirPin
);
	initial begin
		termPin = 8'h00;
		runPin = 1'b0;
		storeKeyPin = 1'b0;
		encStepPin = 1'b0;
		encDirPin = 1'b0;
	end
	task automatic setTerms(input logic [7:0] v);
		termPin <= v;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic setRun(input logic v);
		runPin <= v;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic step(input logic up);
		encDirPin <= up;
		encStepPin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		encStepPin <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
	// Key pressed only once the value is on show
	task automatic press(input int hold);
		storeKeyPin <= 1'b1;
		repeat (hold) @(posedge sys_clk);
		storeKeyPin <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule
